// File: core/ssl_link_status.sv
// per-lane link status bank: error counters, threshold flags, sync
// levels, a small control set and a masked interrupt.
// assumes lane inputs synchronous to clk; error inputs are one-cycle pulses.
//
// What this block does
// - status bit 7 shows disparity error count at or above the threshold
// - status bit 6 shows not-in-table symbol count at or above the threshold
// - status bit 5 shows unexpected control character count at or above threshold
// - each error bit reads 0 below threshold, 1 at or above it
// - status bit 4 reads 1 when deskew achieved, 0 when failed
// - status bit 3 reads 1 with initial alignment sync, 0 when lost
// - status bit 2 reads 1 when configuration checksum is correct
// - status bit 1 reads 1 while frame sync is held
// - status bit 0 reads 1 while code group sync is held
`timescale 1ns/10ps
module ssl_link_status #(
    parameter int NUM_LANES = ssl_pkg::NUM_LANES,
    parameter int CNT_W = ssl_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire ssl_pkg::ssl_bus_req_s bus_req,
    output logic [ssl_pkg::DATA_W-1:0] rd_data_q,
    input wire ssl_pkg::ssl_lane_in_s [NUM_LANES-1:0] lane_in,
    output logic skip_alignment_sequence_q,
    output logic [CNT_W-1:0] error_count_threshold_q,
    output logic irq_q
);
    import ssl_pkg::*;

    // true when the address falls on a lane status byte
    function automatic logic is_lane_addr(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - LANE_STATUS_BASE;
        return (a >= LANE_STATUS_BASE) && (off < ADDR_W'(NUM_LANES));
    endfunction

    // which lane a status address names
    function automatic int lane_of(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - LANE_STATUS_BASE;
        return int'(off);
    endfunction

    logic [DATA_W-1:0] lane_stat_q [NUM_LANES];
    logic [DATA_W-1:0] lane_stat_d [NUM_LANES];
    logic [CNT_W-1:0] disp_cnt_q [NUM_LANES];
    logic [CNT_W-1:0] invalid_cnt_q [NUM_LANES];
    logic [CNT_W-1:0] unexp_cnt_q [NUM_LANES];
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic cnt_clr;
    logic wr_ctrl;
    logic wr_irq_stat;

    assign wr_ctrl = bus_req.wr_en && (bus_req.addr == CTRL_ADDR);
    assign wr_irq_stat = bus_req.wr_en && (bus_req.addr == IRQ_STAT_ADDR);
    // clear is a write-one pulse, never stored
    assign cnt_clr = wr_ctrl && bus_req.wdata[CTRL_CLR_BIT];

    genvar i;
    generate
        for (i = 0; i < NUM_LANES; i++) begin : g_lane
            // saturating counters so a burst never wraps back under threshold
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    disp_cnt_q[i] <= '0;
                    invalid_cnt_q[i] <= '0;
                    unexp_cnt_q[i] <= '0;
                end else if (cnt_clr) begin
                    disp_cnt_q[i] <= '0;
                    invalid_cnt_q[i] <= '0;
                    unexp_cnt_q[i] <= '0;
                end else begin
                    if (lane_in[i].disp_err && !(&disp_cnt_q[i])) begin
                        disp_cnt_q[i] <= disp_cnt_q[i] + 1'b1;
                    end
                    if (lane_in[i].invalid_err && !(&invalid_cnt_q[i])) begin
                        invalid_cnt_q[i] <= invalid_cnt_q[i] + 1'b1;
                    end
                    if (lane_in[i].unexp_err && !(&unexp_cnt_q[i])) begin
                        unexp_cnt_q[i] <= unexp_cnt_q[i] + 1'b1;
                    end
                end
            end

            // a saturated counter must hold until software clears it
            property p_cnt_hold;
                @(posedge clk) disable iff (!resetn)
                (&disp_cnt_q[i] && !cnt_clr) |=> &disp_cnt_q[i];
            endproperty
            a_cnt_hold: assert property (p_cnt_hold)
                else $error("disparity counter wrapped past saturation");

            // next status byte: thresholds compared, sync levels sampled
            always_comb begin
                lane_stat_d[i] = '0;
                lane_stat_d[i][DISP_BIT] = disp_cnt_q[i] >= error_count_threshold_q;
                lane_stat_d[i][INVALID_BIT] = invalid_cnt_q[i] >= error_count_threshold_q;
                lane_stat_d[i][UNEXP_BIT] = unexp_cnt_q[i] >= error_count_threshold_q;
                lane_stat_d[i][DESKEW_BIT] = lane_in[i].deskew_done;
                lane_stat_d[i][ALIGN_BIT] = lane_in[i].align_sync;
                lane_stat_d[i][CHECKSUM_BIT] = lane_in[i].checksum_ok;
                lane_stat_d[i][FRAME_BIT] = lane_in[i].frame_lock;
                lane_stat_d[i][CG_BIT] = lane_in[i].cg_lock;
            end

            // status byte only follows hardware; bus writes never touch it
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    lane_stat_q[i] <= LANE_STATUS_RST;
                end else begin
                    lane_stat_q[i] <= lane_stat_d[i];
                end
            end

            property p_disp_flag;
                @(posedge clk) disable iff (!resetn)
                ##1 lane_stat_q[i][DISP_BIT] ==
                    ($past(disp_cnt_q[i]) >= $past(error_count_threshold_q));
            endproperty
            a_disp_flag: assert property (p_disp_flag)
                else $error("disparity flag disagrees with count");

            property p_invalid_flag;
                @(posedge clk) disable iff (!resetn)
                (invalid_cnt_q[i] >= error_count_threshold_q) |=>
                    lane_stat_q[i][INVALID_BIT];
            endproperty
            a_invalid_flag: assert property (p_invalid_flag)
                else $error("not-in-table flag missing at threshold");

            property p_unexp_flag;
                @(posedge clk) disable iff (!resetn)
                (unexp_cnt_q[i] >= error_count_threshold_q) |=>
                    lane_stat_q[i][UNEXP_BIT];
            endproperty
            a_unexp_flag: assert property (p_unexp_flag)
                else $error("unexpected control flag missing at threshold");

            property p_below_clear;
                @(posedge clk) disable iff (!resetn)
                (disp_cnt_q[i] < error_count_threshold_q &&
                 unexp_cnt_q[i] < error_count_threshold_q) |=>
                    !lane_stat_q[i][DISP_BIT] && !lane_stat_q[i][UNEXP_BIT];
            endproperty
            a_below_clear: assert property (p_below_clear)
                else $error("error flag set below threshold");

            property p_deskew;
                @(posedge clk) disable iff (!resetn)
                ##1 lane_stat_q[i][DESKEW_BIT] == $past(lane_in[i].deskew_done);
            endproperty
            a_deskew: assert property (p_deskew)
                else $error("deskew bit does not follow input");

            property p_align;
                @(posedge clk) disable iff (!resetn)
                $fell(lane_in[i].align_sync) |=> !lane_stat_q[i][ALIGN_BIT];
            endproperty
            a_align: assert property (p_align)
                else $error("alignment loss not shown");

            property p_checksum;
                @(posedge clk) disable iff (!resetn)
                lane_in[i].checksum_ok [*2] |-> lane_stat_q[i][CHECKSUM_BIT];
            endproperty
            a_checksum: assert property (p_checksum)
                else $error("checksum bit not set for good checksum");

            property p_frame;
                @(posedge clk) disable iff (!resetn)
                ##1 lane_stat_q[i][FRAME_BIT] == $past(lane_in[i].frame_lock);
            endproperty
            a_frame: assert property (p_frame)
                else $error("frame lock bit does not follow input");

            property p_cg;
                @(posedge clk) disable iff (!resetn)
                $rose(lane_in[i].cg_lock) |=> lane_stat_q[i][CG_BIT];
            endproperty
            a_cg: assert property (p_cg)
                else $error("code group lock not shown");
        end
    endgenerate

    // threshold register drives all lane comparators
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            error_count_threshold_q <= CNT_W'(THRESH_RST);
        end else if (bus_req.wr_en && bus_req.addr == THRESH_ADDR) begin
            error_count_threshold_q <= bus_req.wdata[CNT_W-1:0];
        end
    end

    // new threshold must be in place the cycle after its write
    property p_thresh_wr;
        @(posedge clk) disable iff (!resetn)
        (bus_req.wr_en && bus_req.addr == THRESH_ADDR) |=>
            error_count_threshold_q == $past(bus_req.wdata[CNT_W-1:0]);
    endproperty
    a_thresh_wr: assert property (p_thresh_wr)
        else $error("threshold write not taken");

    // skip mode: alignment-derived bits become meaningless to software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            skip_alignment_sequence_q <= 1'b0;
        end else if (wr_ctrl) begin
            skip_alignment_sequence_q <= bus_req.wdata[CTRL_SKIP_BIT];
        end
    end

    // interrupt events from status transitions across all lanes
    always_comb begin
        irq_ev = '0;
        for (int l = 0; l < NUM_LANES; l++) begin
            if ((lane_stat_d[l][DISP_BIT] && !lane_stat_q[l][DISP_BIT]) ||
                (lane_stat_d[l][INVALID_BIT] && !lane_stat_q[l][INVALID_BIT]) ||
                (lane_stat_d[l][UNEXP_BIT] && !lane_stat_q[l][UNEXP_BIT])) begin
                irq_ev[IRQ_ERR_BIT] = 1'b1;
            end
            if (!lane_stat_d[l][CG_BIT] && lane_stat_q[l][CG_BIT]) begin
                irq_ev[IRQ_CG_LOSS_BIT] = 1'b1;
            end
            // loss of alignment-derived sync means nothing in skip mode
            if (!skip_alignment_sequence_q) begin
                if (!lane_stat_d[l][FRAME_BIT] && lane_stat_q[l][FRAME_BIT]) begin
                    irq_ev[IRQ_FRAME_LOSS_BIT] = 1'b1;
                end
                if ((!lane_stat_d[l][ALIGN_BIT] && lane_stat_q[l][ALIGN_BIT]) ||
                    (!lane_stat_d[l][DESKEW_BIT] && lane_stat_q[l][DESKEW_BIT])) begin
                    irq_ev[IRQ_ALIGN_LOSS_BIT] = 1'b1;
                end
            end
        end
    end

    // skip mode must keep alignment-derived losses out of the interrupt status
    property p_skip_quiet;
        @(posedge clk) disable iff (!resetn)
        skip_alignment_sequence_q |->
            !irq_ev[IRQ_FRAME_LOSS_BIT] && !irq_ev[IRQ_ALIGN_LOSS_BIT];
    endproperty
    a_skip_quiet: assert property (p_skip_quiet)
        else $error("alignment loss raised in skip mode");

    // write-one-to-clear; a new event in the same cycle wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_irq_stat) begin
            irq_stat_d = irq_stat_q & ~bus_req.wdata[IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_ev;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (bus_req.wr_en && bus_req.addr == IRQ_MASK_ADDR) begin
            irq_mask_q <= bus_req.wdata[IRQ_W-1:0];
        end
    end

    // irq registered from status as it stands after this edge and mask as it stands before it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // level follows status and mask once the mask has settled
    property p_irq_level;
        @(posedge clk) disable iff (!resetn)
        $stable(irq_mask_q) |-> irq_q == |(irq_stat_q & irq_mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status and mask");

    // read data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= '0;
        end else if (bus_req.rd_en) begin
            if (is_lane_addr(bus_req.addr)) begin
                rd_data_q <= lane_stat_q[lane_of(bus_req.addr)];
            end else begin
                case (bus_req.addr)
                    THRESH_ADDR: rd_data_q <= DATA_W'(error_count_threshold_q);
                    CTRL_ADDR: rd_data_q <= DATA_W'(skip_alignment_sequence_q);
                    IRQ_STAT_ADDR: rd_data_q <= DATA_W'(irq_stat_q);
                    IRQ_MASK_ADDR: rd_data_q <= DATA_W'(irq_mask_q);
                    default: rd_data_q <= '0;
                endcase
            end
        end else begin
            rd_data_q <= '0;
        end
    end

    // idle cycles must leave the read port at zero
    property p_rd_idle_zero;
        @(posedge clk) disable iff (!resetn)
        !bus_req.rd_en |=> rd_data_q == '0;
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero)
        else $error("read data not zero outside a read");

    property p_lane3_read;
        @(posedge clk) disable iff (!resetn)
        (bus_req.rd_en && bus_req.addr == LANE3_STATUS_ADDR) |=>
            rd_data_q == $past(lane_stat_q[3]);
    endproperty
    a_lane3_read: assert property (p_lane3_read)
        else $error("lane 3 status read wrong");

    property p_status_wr_ignored;
        @(posedge clk) disable iff (!resetn)
        (bus_req.wr_en && bus_req.addr == LANE4_STATUS_ADDR) |=>
            lane_stat_q[4] == $past(lane_stat_d[4]);
    endproperty
    a_status_wr_ignored: assert property (p_status_wr_ignored)
        else $error("write disturbed lane status");

    property p_irq_set_wins;
        @(posedge clk) disable iff (!resetn)
        (wr_irq_stat && bus_req.wdata[IRQ_CG_LOSS_BIT] && irq_ev[IRQ_CG_LOSS_BIT]) |=>
            irq_stat_q[IRQ_CG_LOSS_BIT];
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins)
        else $error("event lost against clear");

    c_thresh_hit: cover property (@(posedge clk) disable iff (!resetn)
        $rose(lane_stat_q[0][DISP_BIT]));
    c_cg_loss_irq: cover property (@(posedge clk) disable iff (!resetn)
        irq_stat_q[IRQ_CG_LOSS_BIT] && irq_q);
    c_cnt_clear: cover property (@(posedge clk) disable iff (!resetn)
        cnt_clr && disp_cnt_q[0] != '0);
    c_skip_mode: cover property (@(posedge clk) disable iff (!resetn)
        skip_alignment_sequence_q && $fell(lane_in[0].frame_lock));
endmodule

// File: core/ssl_pkg.sv
// constants and carrier types for the per-lane link status bank
// assumes byte-wide registers on a 12-bit address port
package ssl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_LANES = 8;
    localparam int CNT_W = 8;

    // lane status bytes sit at consecutive addresses from this base
    localparam logic [ADDR_W-1:0] LANE_STATUS_BASE = 12'h4b0;
    localparam logic [ADDR_W-1:0] LANE3_STATUS_ADDR = 12'h4b3;
    localparam logic [ADDR_W-1:0] LANE4_STATUS_ADDR = 12'h4b4;
    localparam logic [ADDR_W-1:0] THRESH_ADDR = 12'h4c0;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h4c1;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h4c2;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h4c3;

    // status byte field positions
    localparam int DISP_BIT = 7;
    localparam int INVALID_BIT = 6;
    localparam int UNEXP_BIT = 5;
    localparam int DESKEW_BIT = 4;
    localparam int ALIGN_BIT = 3;
    localparam int CHECKSUM_BIT = 2;
    localparam int FRAME_BIT = 1;
    localparam int CG_BIT = 0;

    // control register fields
    localparam int CTRL_SKIP_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;

    // interrupt status fields
    localparam int IRQ_W = 4;
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_CG_LOSS_BIT = 1;
    localparam int IRQ_FRAME_LOSS_BIT = 2;
    localparam int IRQ_ALIGN_LOSS_BIT = 3;

    // reset values
    localparam logic [DATA_W-1:0] LANE_STATUS_RST = 8'h00;
    localparam logic [CNT_W-1:0] THRESH_RST = 8'hff;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // what the lane decoder and alignment logic hand over each cycle
    typedef struct packed {
        logic disp_err;
        logic invalid_err;
        logic unexp_err;
        logic deskew_done;
        logic align_sync;
        logic checksum_ok;
        logic frame_lock;
        logic cg_lock;
    } ssl_lane_in_s;

    // one register port request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ssl_bus_req_s;
endpackage

// File: tb/ssl_lane_model.sv
// far-side model: the lane decoders and alignment logic feeding the status bank
// assumes the caller is aligned just after a rising clk edge when it calls a task
`timescale 1ns/10ps
module ssl_lane_model
    import ssl_pkg::*;
#(
    parameter int NL = 8
) (
    input wire logic clk,
    input wire logic resetn,
    output ssl_pkg::ssl_lane_in_s [NL-1:0] lane_in
);
    // quiet lanes at time zero and whenever reset drops
    initial lane_in = '0;
    always @(negedge resetn) begin
        lane_in <= '0;
    end

    // sync levels change right after an edge and then stand
    task automatic set_level(input int ln, input logic [4:0] v);
        lane_in[ln][4:0] <= v;
    endtask

    // one-cycle error pulse; gap lets the lane be slow between errors
    task automatic pulse(input int ln, input int kind, input int gap);
        @(posedge clk);
        lane_in[ln][7-kind] <= 1'b1;
        @(posedge clk);
        lane_in[ln][7-kind] <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
endmodule

// File: tb/ssl_link_status_bench.sv
// self-checking bench for the lane link status bank
// assumes the design's own assertions run beside it; reads checked via a queue
`timescale 1ns/10ps
module ssl_link_status_bench;
    import ssl_pkg::*;
    logic clk;
    logic resetn;
    ssl_bus_req_s bus_req;
    logic [DATA_W-1:0] rd_data_q;
    ssl_lane_in_s [NUM_LANES-1:0] lane_in;
    logic skip_q;
    logic [CNT_W-1:0] thr_q;
    logic irq_q;
    int fail_count;
    int checks_done;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    logic [4:0] lvl[NUM_LANES];
    logic rd_seen;

    ssl_link_status uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data_q(rd_data_q),
        .lane_in(lane_in), .skip_alignment_sequence_q(skip_q), .error_count_threshold_q(thr_q),
        .irq_q(irq_q));
    ssl_lane_model #(.NL(NUM_LANES)) lm (.clk(clk), .resetn(resetn), .lane_in(lane_in));

    // 250 mhz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // each bus task assigns every field once, so back-to-back ops never race
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        bus_req.wr_en <= w;
        bus_req.rd_en <= r;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 12'h000, 8'h00);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk("read data", rd_data_q & msk_q.pop_front(), exp_q.pop_front());
        end
        rd_seen = bus_req.rd_en;
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end

    initial begin
        resetn = 1'b0;
        bus_req = '0;
        rd_seen = 1'b0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(32'hbb96));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // reset values and every lane byte at zero
        chk("threshold", thr_q, 8'hff);
        chk("skip", {7'h0, skip_q}, 8'h00);
        chk("irq", {7'h0, irq_q}, 8'h00);
        for (int i = 0; i < NUM_LANES; i++) rd(LANE_STATUS_BASE + 12'(i), 8'h00, 8'hff);
        idle(2);
        $display("test reset done");
        // random sync levels, one byte per lane in lane order
        for (int i = 0; i < NUM_LANES; i++) begin
            // lane 5 starts fully locked so the skip test sees every loss
            lvl[i] = (i == 5) ? 5'h1f : 5'($urandom);
            lm.set_level(i, lvl[i]);
        end
        idle(2);
        for (int i = 0; i < NUM_LANES; i++) rd(LANE_STATUS_BASE + 12'(i), {3'h0, lvl[i]}, 8'hff);
        wr(LANE3_STATUS_ADDR, 8'hff);
        rd(LANE3_STATUS_ADDR, {3'h0, lvl[3]}, 8'hff);
        wr(LANE4_STATUS_ADDR, 8'h00);
        rd(LANE4_STATUS_ADDR, {3'h0, lvl[4]}, 8'hff);
        rd(12'h4d0, 8'h00, 8'hff);
        idle(2);
        $display("test levels done");
        // error bit flips exactly when the count reaches the threshold
        wr(THRESH_ADDR, 8'h03);
        wr(CTRL_ADDR, 8'h02);
        idle(2);
        for (int e = 0; e < 3; e++) begin
            lm.pulse(e + 2, e, 0);
            lm.pulse(e + 2, e, int'($urandom % 3));
            idle(3);
            rd(LANE_STATUS_BASE + 12'(e + 2), {3'h0, lvl[e + 2]}, 8'hff);
            idle(1);
            lm.pulse(e + 2, e, 0);
            idle(3);
            rd(LANE_STATUS_BASE + 12'(e + 2), (8'h80 >> e) | {3'h0, lvl[e + 2]}, 8'hff);
            idle(1);
        end
        wr(THRESH_ADDR, 8'h00);
        idle(2);
        rd(LANE_STATUS_BASE, {3'h7, lvl[0]}, 8'hff);
        idle(2);
        $display("test thresholds done");
        // interrupt raised, masked, unmasked and cleared
        rd(IRQ_STAT_ADDR, 8'h01, 8'hff);
        idle(1);
        chk("irq masked", {7'h0, irq_q}, 8'h00);
        wr(IRQ_MASK_ADDR, 8'h01);
        for (int k = 0; k < 4 && irq_q !== 1'b1; k++) idle(1);
        chk("irq unmasked", {7'h0, irq_q}, 8'h01);
        wr(CTRL_ADDR, 8'h02);
        wr(THRESH_ADDR, 8'hff);
        idle(2);
        wr(IRQ_STAT_ADDR, 8'h01);
        idle(2);
        chk("irq cleared", {7'h0, irq_q}, 8'h00);
        rd(IRQ_STAT_ADDR, 8'h00, 8'hff);
        idle(2);
        $display("test interrupt done");
        // skip mode: alignment, checksum, deskew and frame bits are disregarded
        wr(CTRL_ADDR, 8'h01);
        lm.set_level(5, 5'h00);
        // clear lands on the same edge as the lock loss: the loss must win
        wr(IRQ_STAT_ADDR, 8'h02);
        idle(1);
        chk("skip", {7'h0, skip_q}, 8'h01);
        rd(CTRL_ADDR, 8'h01, 8'hff);
        rd(THRESH_ADDR, 8'hff, 8'hff);
        rd(LANE_STATUS_BASE + 12'd5, 8'h00, 8'he1);
        rd(IRQ_STAT_ADDR, 8'h02, 8'hff);
        idle(3);
        $display("test skip done");
        final_report();
    end
endmodule
